// ### rtl/flash_spi_pkg.sv
// Shared constants for the serial flash front end and its host controller
// Function
// - Sample serial input on serial clock rising edge
// - Change serial output only after falling edge
// - Work with clock idling low or high
// - Host frames each command with select low
// - Enter pause on hold low with clock low
// - Leave pause on hold high with clock low
// - Paused: output floats, inputs ignored, state kept
// - Select high while paused resets interface logic
// - Host resumes with hold high, select low
// - Refuse status write if protect pin low, locked
// - Bit 0 read-only busy, resets to zero
// - Bit 1 read-only write enable latch, zero
// - Reject program or erase without enable latch
// - Enable latch cleared by listed completions
// - Bits 2-5 block protect, reset 0111
// - Bit 6 read-only auto increment mode flag
// - Bit 7 protect lock, freezes protect bits
// - Host only polls status while busy
// - Bytes are eight bits, MSB first
// - Select rising early abandons the command
// - Lock also blocks changes to itself
// - Host sends write enable before writes; the bench sends some status writes without it
package flash_spi_pkg;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_STATUS_READ   = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_BYTE_PROGRAM  = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A  = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B  = 8'hC7;
  localparam logic [7:0] OP_AUTO_INC_PROG = 8'hAD;
  // ==========================================================
  // Status layout and power-up values
  localparam int         ST_BUSY     = 0;
  localparam int         ST_WEL      = 1;
  localparam int         ST_BP_LO    = 2;
  localparam int         ST_AAI      = 6;
  localparam int         ST_LOCK     = 7;
  localparam logic [3:0] BP_RESET    = 4'h7;
  localparam logic       WEL_RESET   = 1'b0;
  localparam logic       LOCK_RESET  = 1'b0;
  // ==========================================================
  // Byte counts of complete commands
  localparam logic [2:0] LEN_CMD_ONLY   = 3'h1;
  localparam logic [2:0] LEN_STATUS_WR  = 3'h2;
  localparam logic [2:0] LEN_AAI_NEXT   = 3'h3;
  localparam logic [2:0] LEN_ERASE      = 3'h4;
  localparam logic [2:0] LEN_PROGRAM    = 3'h5;
  localparam logic [2:0] LEN_AAI_FIRST  = 3'h6;
  // ==========================================================
  // Host timing: serial clock half period in clk cycles
  localparam logic [3:0] HALF_CYCLES = 4'h6;
  // ==========================================================
  // Host register map (byte addresses)
  localparam logic [3:0] ADDR_TX     = 4'h0;
  localparam logic [3:0] ADDR_CTRL   = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_RX     = 4'hC;
  localparam int         CTRL_LEN_LO = 0;
  localparam int         CTRL_CPOL   = 3;
  localparam int         CTRL_START  = 4;
  localparam int         CTRL_HOLD   = 5;
  localparam int         CTRL_WP_N   = 6;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### rtl/flash_spi_if.sv
// Link between the serial flash front end and its host controller
interface flash_spi_if;
  logic sck;     // Serial clock from host
  logic cs_n;    // Chip select, active low
  logic si;      // Serial data into flash
  logic so;      // Serial data out of flash
  logic so_oe;   // Flash drives so while high
  logic hold_n;  // Pause request, active low
  logic wp_n;    // Write protect, active low
  logic so_line; // Resolved so wire, pulled up when floating

  assign so_line = so_oe ? so : 1'b1;

  modport flash (input sck, cs_n, si, hold_n, wp_n, output so, so_oe);
  modport ctrl  (output sck, cs_n, si, hold_n, wp_n, input so_line);
endinterface

// ### rtl/flash_spi_front_end.sv
// Serial flash interface front end with status register
module flash_spi_front_end
  import flash_spi_pkg::*;
(
  input  wire logic        clk,         // 20 MHz clock
  input  wire logic        rst_n,       // Async reset, active low
  flash_spi_if.flash       link,        // Serial link
  input  wire logic        op_busy,     // Program or erase running
  input  wire logic        op_done,     // Program/erase finished pulse
  input  wire logic        aai_active,  // Auto increment mode on
  input  wire logic        aai_end,     // Auto increment ended pulse
  output logic             cmd_valid,   // Accepted write command pulse
  output logic [7:0]       cmd_op,      // Its opcode
  output logic [23:0]      cmd_addr,    // Its address
  output logic [15:0]      cmd_data,    // Last two data bytes
  output logic [7:0]       status_q     // Status register copy
);
  typedef struct packed {
    logic [4:0]  sync_m;
    logic [4:0]  sync_s;
    logic        sck_d;
    logic        cs_d;
    logic        paused;
    logic [2:0]  bitcnt;
    logic [2:0]  bytecnt;
    logic [7:0]  shreg;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [15:0] data;
    logic        reading;
    logic        talk;
    logic [2:0]  ocnt;
    logic        so;
    logic        so_oe;
    logic        write_enable_latch;
    logic [3:0]  bp;
    logic        lock;
    logic        cmd_valid;
    logic [7:0]  cmd_op;
    logic [23:0] cmd_addr;
    logic [15:0] cmd_data;
    logic [7:0]  status;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // Bytes a write command needs; zero for other opcodes
  function automatic logic [2:0] write_len(input logic [7:0] op, input logic auto_increment_program);
    unique case (op)
      OP_BYTE_PROGRAM:                                    write_len = LEN_PROGRAM;
      OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE: write_len = LEN_ERASE;
      OP_CHIP_ERASE_A, OP_CHIP_ERASE_B:                   write_len = LEN_CMD_ONLY;
      OP_AUTO_INC_PROG:                                   write_len = auto_increment_program ? LEN_AAI_NEXT : LEN_AAI_FIRST;
      default:                                            write_len = 3'h0;
    endcase
  endfunction

  logic sck_s;
  logic si_s;
  logic cs_s;
  logic hold_s;
  logic wp_s;
  logic sck_rise;
  logic sck_fall;
  logic active;
  logic locked;
  logic [7:0] sh_in;
  logic [7:0] stat;

  assign sck_s  = s_r.sync_s[0];
  assign si_s   = s_r.sync_s[1];
  assign cs_s   = s_r.sync_s[2];
  assign hold_s = s_r.sync_s[3];
  assign wp_s   = s_r.sync_s[4];

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync_m = {link.wp_n, link.hold_n, link.cs_n, link.si, link.sck};
    s_nxt.sync_s = s_r.sync_m;
    s_nxt.sck_d = sck_s;
    s_nxt.cs_d = cs_s;
    s_nxt.cmd_valid = 1'b0;
    sck_rise = sck_s & ~s_r.sck_d;
    sck_fall = ~sck_s & s_r.sck_d;
    sh_in = {s_r.shreg[6:0], si_s};
    locked = ~wp_s & s_r.lock;

    // While selected, pause state follows hold only while the clock is low; deselected, hold high ends it
    if (!cs_s) begin
      if (!sck_s) begin
        s_nxt.paused = ~hold_s;
      end
    end else begin
      s_nxt.paused = s_r.paused & ~hold_s;
    end
    active = ~cs_s & ~s_r.paused;

    // Completions clear the latch first so a same-cycle enable wins
    if (op_done || aai_end) begin
      s_nxt.write_enable_latch = 1'b0;
    end

    // Command execution at the end of a frame
    if (cs_s && !s_r.cs_d && !s_r.paused && s_r.bitcnt == 3'h0 && !op_busy) begin
      unique case (s_r.opcode)
        OP_WRITE_ENABLE: begin
          if (s_r.bytecnt == LEN_CMD_ONLY) begin
            s_nxt.write_enable_latch = 1'b1;
          end
        end
        OP_WRITE_DISABLE: begin
          if (s_r.bytecnt == LEN_CMD_ONLY) begin
            s_nxt.write_enable_latch = 1'b0;
          end
        end
        OP_STATUS_WRITE: begin
          if (s_r.bytecnt == LEN_STATUS_WR) begin
            s_nxt.write_enable_latch = 1'b0;
            if (!locked) begin
              s_nxt.bp = s_r.data[ST_AAI-1:ST_BP_LO];
              s_nxt.lock = s_r.data[ST_LOCK];
            end
          end
        end
        default: begin
          if (write_len(s_r.opcode, aai_active) != 3'h0 &&
              s_r.bytecnt >= write_len(s_r.opcode, aai_active) && s_r.write_enable_latch) begin
            s_nxt.cmd_valid = 1'b1;
            s_nxt.cmd_op = s_r.opcode;
            s_nxt.cmd_addr = s_r.addr;
            s_nxt.cmd_data = s_r.data;
          end
        end
      endcase
    end

    stat = {s_nxt.lock, aai_active, s_nxt.bp, s_nxt.write_enable_latch, op_busy};
    s_nxt.status = stat;

    if (cs_s) begin
      // Frame ended or never started: clear interface position
      s_nxt.bitcnt = 3'h0;
      s_nxt.bytecnt = 3'h0;
      s_nxt.reading = 1'b0;
      s_nxt.talk = 1'b0;
      s_nxt.ocnt = 3'h0;
      s_nxt.so_oe = 1'b0;
    end else if (!active) begin
      s_nxt.so_oe = 1'b0;
    end else begin
      // Driving resumes after a pause without waiting for a clock edge
      s_nxt.so_oe = s_r.talk;
      if (sck_rise) begin
        s_nxt.shreg = sh_in;
        s_nxt.bitcnt = s_r.bitcnt + 3'h1;
        if (s_r.bitcnt == 3'h7) begin
          if (s_r.bytecnt != 3'h7) begin
            s_nxt.bytecnt = s_r.bytecnt + 3'h1;
          end
          if (s_r.bytecnt == 3'h0) begin
            s_nxt.opcode = sh_in;
            s_nxt.reading = (sh_in == OP_STATUS_READ);
          end else begin
            if (s_r.bytecnt <= 3'h3) begin
              s_nxt.addr = {s_r.addr[15:0], sh_in};
            end
            s_nxt.data = {s_r.data[7:0], sh_in};
          end
        end
      end
      if (sck_fall && s_r.reading) begin
        s_nxt.so = s_r.status[3'h7 - s_r.ocnt];
        s_nxt.so_oe = 1'b1;
        s_nxt.talk = 1'b1;
        s_nxt.ocnt = s_r.ocnt + 3'h1;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{sync_m: 5'h1F, sync_s: 5'h1F, sck_d: 1'b0, cs_d: 1'b1, paused: 1'b0,
               bitcnt: 3'h0, bytecnt: 3'h0, shreg: 8'h00, opcode: 8'h00, addr: 24'h000000,
               data: 16'h0000, reading: 1'b0, talk: 1'b0, ocnt: 3'h0, so: 1'b0, so_oe: 1'b0,
               write_enable_latch: WEL_RESET, bp: BP_RESET, lock: LOCK_RESET, cmd_valid: 1'b0,
               cmd_op: 8'h00, cmd_addr: 24'h000000, cmd_data: 16'h0000,
               status: {LOCK_RESET, 1'b0, BP_RESET, WEL_RESET, 1'b0}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.so    = s_r.so;
  assign link.so_oe = s_r.so_oe;
  assign cmd_valid  = s_r.cmd_valid;
  assign cmd_op     = s_r.cmd_op;
  assign cmd_addr   = s_r.cmd_addr;
  assign cmd_data   = s_r.cmd_data;
  assign status_q   = s_r.status;
endmodule

// ### rtl/flash_spi_host.sv
// Host controller for the serial flash link, programmed over AXI4-Lite
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
module flash_spi_host
  import flash_spi_pkg::*;
(
  input  wire logic        clk,      // 20 MHz clock
  input  wire logic        rst_n,    // Async reset, active low
  flash_spi_if.ctrl        link,     // Serial link
  input  wire logic [3:0]  awaddr,   // Write address
  input  wire logic        awvalid,  // Write address valid
  output logic             awready,  // Write address ready
  input  wire logic [31:0] wdata,    // Write data
  input  wire logic [3:0]  wstrb,    // Write strobes
  input  wire logic        wvalid,   // Write data valid
  output logic             wready,   // Write data ready
  output logic [1:0]       bresp,    // Write response
  output logic             bvalid,   // Write response valid
  input  wire logic        bready,   // Write response ready
  input  wire logic [3:0]  araddr,   // Read address
  input  wire logic        arvalid,  // Read address valid
  output logic             arready,  // Read address ready
  output logic [31:0]      rdata,    // Read data
  output logic [1:0]       rresp,    // Read response
  output logic             rvalid,   // Read data valid
  input  wire logic        rready    // Read data ready
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LOW  = 4'h2,
    ST_HIGH = 4'h4,
    ST_TAIL = 4'h8
  } phase_t;

  typedef struct packed {
    logic        awready, wready, bvalid, arready, rvalid;
    logic        aw_got, w_got;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [31:0] tx;
    logic [2:0]  len;
    logic        cpol, hold_req, wp_lvl;
    logic        busy;
    logic [31:0] rx;
    phase_t      phase;
    logic [4:0]  cnt;
    logic [5:0]  bits;
    logic [31:0] sh;
    logic        so_m, so_s;
    logic        sck, cs_n, si, hold_n, wp_n;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  logic [31:0] ctrl_new;

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    ctrl_new = 32'h00000000;
    s_nxt.so_m = link.so_line;
    s_nxt.so_s = s_r.so_m;

    // AXI4-Lite write side
    if (awvalid && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_addr = awaddr;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_data = wdata;
      s_nxt.w_strb = wstrb;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      unique case (s_r.aw_addr)
        ADDR_TX: begin
          if (!s_r.busy) begin
            s_nxt.tx = merge(s_r.tx, s_r.w_data, s_r.w_strb);
          end
        end
        ADDR_CTRL: begin
          ctrl_new = merge({25'h0, s_r.wp_lvl, s_r.hold_req, 1'b0, s_r.cpol, s_r.len},
                           s_r.w_data, s_r.w_strb);
          s_nxt.hold_req = ctrl_new[CTRL_HOLD];
          s_nxt.wp_lvl = ctrl_new[CTRL_WP_N];
          if (!s_r.busy) begin
            s_nxt.len = ctrl_new[CTRL_LEN_LO +: 3];
            s_nxt.cpol = ctrl_new[CTRL_CPOL];
            s_nxt.sck = ctrl_new[CTRL_CPOL];
            if (ctrl_new[CTRL_START] && ctrl_new[CTRL_LEN_LO +: 3] != 3'h0 &&
                ctrl_new[CTRL_LEN_LO +: 3] <= 3'h4) begin
              s_nxt.busy = 1'b1;
              s_nxt.sh = s_r.tx;
              s_nxt.bits = {ctrl_new[CTRL_LEN_LO +: 3], 3'h0};
              s_nxt.cnt = 5'h00;
              s_nxt.cs_n = 1'b0;
              s_nxt.sck = 1'b0;
              s_nxt.si = s_r.tx[31];
              s_nxt.phase = ST_LOW;
            end
          end
        end
        ADDR_STATUS, ADDR_RX: begin
        end
        default: s_nxt.bresp = RESP_SLVERR;
      endcase
    end
    s_nxt.awready = ~s_nxt.aw_got & ~s_nxt.bvalid;
    s_nxt.wready = ~s_nxt.w_got & ~s_nxt.bvalid;

    // AXI4-Lite read side
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      unique case (araddr)
        ADDR_TX:     s_nxt.rdata = s_r.tx;
        ADDR_CTRL:   s_nxt.rdata = {25'h0, s_r.wp_lvl, s_r.hold_req, 1'b0, s_r.cpol, s_r.len};
        ADDR_STATUS: s_nxt.rdata = {31'h0, s_r.busy};
        ADDR_RX:     s_nxt.rdata = s_r.rx;
        default: begin
          s_nxt.rdata = 32'h00000000;
          s_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    s_nxt.arready = ~s_nxt.rvalid;

    // Serial engine
    s_nxt.hold_n = ~s_r.hold_req;
    s_nxt.wp_n = s_r.wp_lvl;
    unique case (s_r.phase)
      ST_IDLE: begin
      end
      ST_LOW: begin
        // Hold parks the clock low so the pause begins cleanly
        if (!s_r.hold_req && s_r.hold_n) begin
          s_nxt.cnt = s_r.cnt + 5'h01;
          if (s_r.cnt == {1'b0, HALF_CYCLES} - 5'h01) begin
            s_nxt.cnt = 5'h00;
            s_nxt.sck = 1'b1;
            s_nxt.phase = ST_HIGH;
          end
        end
      end
      ST_HIGH: begin
        s_nxt.cnt = s_r.cnt + 5'h01;
        if (s_r.cnt == {1'b0, HALF_CYCLES} - 5'h01) begin
          s_nxt.cnt = 5'h00;
          s_nxt.rx = {s_r.rx[30:0], s_r.so_s};
          s_nxt.sh = {s_r.sh[30:0], 1'b0};
          s_nxt.bits = s_r.bits - 6'h01;
          if (s_r.bits == 6'h01) begin
            s_nxt.sck = s_r.cpol;
            s_nxt.phase = ST_TAIL;
          end else begin
            s_nxt.sck = 1'b0;
            s_nxt.si = s_r.sh[30];
            s_nxt.phase = ST_LOW;
          end
        end
      end
      ST_TAIL: begin
        s_nxt.cnt = s_r.cnt + 5'h01;
        if (s_r.cnt == {1'b0, HALF_CYCLES} - 5'h01) begin
          s_nxt.cs_n = 1'b1;
        end
        if (s_r.cnt == {HALF_CYCLES, 1'b0} - 5'h01) begin
          s_nxt.cnt = 5'h00;
          s_nxt.busy = 1'b0;
          s_nxt.phase = ST_IDLE;
        end
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{awready: 1'b1, wready: 1'b1, bvalid: 1'b0, arready: 1'b1, rvalid: 1'b0,
               aw_got: 1'b0, w_got: 1'b0, aw_addr: 4'h0, w_data: 32'h0, w_strb: 4'h0,
               bresp: 2'h0, rresp: 2'h0, rdata: 32'h0, tx: 32'h0, len: 3'h0, cpol: 1'b0,
               hold_req: 1'b0, wp_lvl: 1'b1, busy: 1'b0, rx: 32'h0, phase: ST_IDLE,
               cnt: 5'h00, bits: 6'h00, sh: 32'h0, so_m: 1'b1, so_s: 1'b1, sck: 1'b0,
               cs_n: 1'b1, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready     = s_r.awready;
  assign wready      = s_r.wready;
  assign bvalid      = s_r.bvalid;
  assign bresp       = s_r.bresp;
  assign arready     = s_r.arready;
  assign rvalid      = s_r.rvalid;
  assign rdata       = s_r.rdata;
  assign rresp       = s_r.rresp;
  assign link.sck    = s_r.sck;
  assign link.cs_n   = s_r.cs_n;
  assign link.si     = s_r.si;
  assign link.hold_n = s_r.hold_n;
  assign link.wp_n   = s_r.wp_n;
endmodule

// ### sim/flash_spi_chk.sv
// Concurrent checks on the serial link between host and flash front end
module flash_spi_chk (
  input wire logic clk,     // 20 MHz clock
  input wire logic rst_n,   // Async reset, active low
  input wire logic sck,     // Serial clock
  input wire logic cs_n,    // Select, active low
  input wire logic si,      // Data to flash
  input wire logic so,      // Data from flash
  input wire logic so_oe,   // Flash drives so
  input wire logic hold_n,  // Pause, active low
  input wire logic wp_n,    // Protect, active low
  input wire logic so_line  // Resolved so wire
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Rising serial clock edges counted within a frame
  typedef struct packed {
    logic       sck_d;
    logic [2:0] rises;
  } chk_state_t;
  chk_state_t st_r;
  chk_state_t st_nxt;
  always_comb begin
    st_nxt       = st_r;
    st_nxt.sck_d = sck;
    if (cs_n) begin
      st_nxt.rises = 3'h0;
    end else if (sck && !st_r.sck_d) begin
      st_nxt.rises = st_r.rises + 3'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  // ==========================================================
  // Assertions
  a_so_idle_float: assert property (cs_n [*5] |-> !so_oe && so_line)
    else $error("so driven while deselected");
  a_so_change_low: assert property ($changed(so) && so_oe |-> !sck && !$past(sck))
    else $error("so changed outside clock low phase");
  a_si_stable_high: assert property (sck && $past(sck) |-> $stable(si))
    else $error("si changed while clock high");
  a_hold_out_float: assert property ($fell(hold_n) && !cs_n |-> ##[1:24] !so_oe)
    else $error("so still driven in pause");
  a_hold_sck_frozen: assert property (!hold_n && !sck && !cs_n |=> !sck || hold_n)
    else $error("clock moved during pause");
  a_cs_gap_min: assert property ($rose(cs_n) |-> cs_n [*3])
    else $error("select high time too short");
  a_byte_whole: assert property ($rose(cs_n) |-> st_r.rises == 3'h0)
    else $error("frame ended inside a byte");
  a_sck_half_min: assert property ($changed(sck) && hold_n |=> $stable(sck) [*5])
    else $error("clock phase too short");
  cover property ($rose(cs_n));
  cover property (so_oe && !cs_n);
  cover property (!hold_n && !cs_n);
  cover property (!cs_n && !wp_n);
endmodule

// ### sim/serial_flash_spi_front_end_bench.sv
// Bench joining the flash front end and its host over the serial link
module serial_flash_spi_front_end_bench
  import flash_spi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, op_busy, op_done, aai_active, aai_end, cmd_valid, wp_bit;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rx;
  logic [1:0]  rresp, bresp;
  logic [7:0]  cmd_op, status_q;
  logic [23:0] cmd_addr;
  int          err_count = 0, total_checks = 0, cmd_seen = 0;
  flash_spi_if link ();
  flash_spi_front_end i_flash_spi_front_end (.clk(clk), .rst_n(rst_n), .link(link.flash), .op_busy(op_busy),
    .op_done(op_done), .aai_active(aai_active), .aai_end(aai_end), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(), .status_q(status_q));
  flash_spi_host i_flash_spi_host (.clk(clk), .rst_n(rst_n), .link(link.ctrl), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  flash_spi_chk i_flash_spi_chk (.clk(clk), .rst_n(rst_n), .sck(link.sck), .cs_n(link.cs_n), .si(link.si),
    .so(link.so), .so_oe(link.so_oe), .hold_n(link.hold_n), .wp_n(link.wp_n), .so_line(link.so_line));
  // ==========================================================
  // Clock, accepted command counter, checking and ending
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) cmd_seen <= cmd_seen + 1;
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic check_st(logic [7:0] exp);
    repeat (4) @(posedge clk);
    check("status", {24'h0, status_q}, {24'h0, exp});
  endtask
  task automatic stop_test();
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // Register bus and frame helpers
  task automatic axi_wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic wait_idle();
    logic [1:0] r;
    do axi_rd(ADDR_STATUS, rx, r); while (rx[0] !== 1'b0);
    axi_rd(ADDR_RX, rx, r);
  endtask
  task automatic frame(logic [31:0] tx, logic [2:0] len, logic cpol);
    axi_wr(ADDR_TX, tx);
    axi_wr(ADDR_CTRL, {25'h0, wp_bit, 2'b01, cpol, len});
    wait_idle();
  endtask
  task automatic pulse(logic auto_increment_program);
    aai_end <= auto_increment_program;
    op_done <= !auto_increment_program;
    @(posedge clk);
    aai_end <= 1'b0;
    op_done <= 1'b0;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_power_up();
    logic [1:0] r;
    check_st(8'h1C);
    axi_rd(4'h2, rx, r);
    check("unmapped", {30'h0, r}, {30'h0, RESP_SLVERR});
    axi_wr(4'h2, 32'h0);
    check("unmapped wr", {30'h0, bresp}, {30'h0, RESP_SLVERR});
    axi_wr(ADDR_TX, 32'h0);
    check("mapped wr", {30'h0, bresp}, {30'h0, RESP_OKAY});
  endtask
  task automatic t_hold();
    logic s;
    axi_wr(ADDR_TX, {OP_STATUS_READ, 24'h0});
    axi_wr(ADDR_CTRL, 32'h52);
    repeat (130) @(posedge clk);
    axi_wr(ADDR_CTRL, 32'h60);
    repeat (30) @(posedge clk);
    s = link.sck;
    check("so_oe paused", {31'h0, link.so_oe}, 32'h0);
    check("so paused", {31'h0, link.so_line}, 32'h1);
    repeat (24) @(posedge clk);
    check("sck paused", {31'h0, link.sck}, {31'h0, s});
    axi_wr(ADDR_CTRL, 32'h40);
    wait_idle();
    check("resumed byte", {24'h0, rx[7:0]}, 32'h1C);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 2; m++) begin
      frame({OP_STATUS_READ, 24'h0}, 3'h2, m[0]);
      check("status byte", {24'h0, rx[7:0]}, 32'h1C);
      check("opcode so", {24'h0, rx[15:8]}, 32'hFF);
    end
    frame({OP_WRITE_ENABLE, 24'h0}, 3'h1, 1'b0);
    check_st(8'h1E);
    frame({OP_WRITE_DISABLE, 24'h0}, 3'h1, 1'b1);
    check_st(8'h1C);
  endtask
  task automatic t_status_write();
    frame({OP_WRITE_ENABLE, 24'h0}, 3'h1, 1'b0);
    frame({OP_STATUS_WRITE, 8'h84, 16'h0}, 3'h2, 1'b0);
    check_st(8'h84);
    wp_bit = 1'b0;
    frame({OP_WRITE_ENABLE, 24'h0}, 3'h1, 1'b0);
    frame({OP_STATUS_WRITE, 8'h00, 16'h0}, 3'h2, 1'b0);
    check_st(8'h84);
    wp_bit = 1'b1;
    frame({OP_STATUS_WRITE, 8'h43, 16'h0}, 3'h2, 1'b0);
    check_st(8'h00);
    wp_bit = 1'b0;
    frame({OP_STATUS_WRITE, 8'h0C, 16'h0}, 3'h2, 1'b0);
    check_st(8'h0C);
    wp_bit = 1'b1;
    frame({OP_STATUS_WRITE, 8'h00, 16'h0}, 3'h2, 1'b0);
    check_st(8'h00);
  endtask
  task automatic t_erase();
    logic [7:0] ops [5] = '{OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
    frame({OP_SECTOR_ERASE, 24'h0A0B0C}, 3'h4, 1'b0);
    check("no latch", cmd_seen, 0);
    frame({OP_WRITE_ENABLE, 24'h0}, 3'h1, 1'b0);
    frame({OP_SECTOR_ERASE, 24'h0A0B0C}, 3'h1, 1'b0);
    check("short frame", cmd_seen, 0);
    for (int i = 0; i < 5; i++) begin
      frame({OP_WRITE_ENABLE, 24'h0}, 3'h1, 1'b0);
      frame({ops[i], 24'h0A0B0C}, i < 3 ? 3'h4 : 3'h1, 1'b0);
      check("accepted", cmd_seen, i + 1);
      check("opcode", {24'h0, cmd_op}, {24'h0, ops[i]});
      if (i < 3) check("address", {8'h0, cmd_addr}, 32'h000A0B0C);
      op_busy <= 1'b1;
      frame({OP_STATUS_READ, 24'h0}, 3'h2, 1'b0);
      check("busy byte", {24'h0, rx[7:0]}, 32'h03);
      op_busy <= 1'b0;
      pulse(1'b0);
      check_st(8'h00);
    end
    aai_active <= 1'b1;
    frame({OP_WRITE_ENABLE, 24'h0}, 3'h1, 1'b0);
    check_st(8'h42);
    pulse(1'b1);
    check_st(8'h40);
    aai_active <= 1'b0;
    check_st(8'h00);
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    rst_n = 1'b0;
    wp_bit = 1'b1;
    {op_busy, op_done, aai_active, aai_end, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wstrb, wdata} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_power_up();
    t_hold();
    t_modes();
    t_status_write();
    t_erase();
    stop_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    stop_test();
  end
endmodule
